// *** hw/jtc_pkg.sv ***
// shared constants and types for the test access port and its scan controller
package jtc_pkg;

  localparam int MCLK_PERIOD_NS = 10;
  localparam int IR_W           = 4;
  localparam int DR_MAX         = 32;
  localparam int USER_W         = 8;
  localparam int VEC_W          = 40;
  localparam int TCK_HALF       = 4;
  localparam int RST_TMS_CNT    = 5;

  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] OP_IDCODE  = 4'h1;
  localparam logic [IR_W-1:0] OP_USER    = 4'h2;
  localparam logic [IR_W-1:0] OP_BYPASS  = 4'hF;
  // identification value is arbitrary, bit 0 set
  localparam logic [31:0]     ID_VALUE   = 32'h1000_0001;

  // tms pattern sent bit 0 first
  localparam logic [3:0] IR_PRE     = 4'h3;
  localparam logic [5:0] IR_PRE_LEN = 6'h04;
  localparam logic [3:0] DR_PRE     = 4'h1;
  localparam logic [5:0] DR_PRE_LEN = 6'h03;
  localparam logic [5:0] RST_TMS    = 6'h1F;
  localparam logic [5:0] RST_LEN    = 6'h06;

  typedef enum logic [15:0] {
    ST_TLR       = 16'h0001,
    ST_IDLE      = 16'h0002,
    ST_SEL_DR    = 16'h0004,
    ST_CAP_DR    = 16'h0008,
    ST_SHIFT_DR  = 16'h0010,
    ST_EXIT1_DR  = 16'h0020,
    ST_PAUSE_DR  = 16'h0040,
    ST_EXIT2_DR  = 16'h0080,
    ST_UPD_DR    = 16'h0100,
    ST_SEL_IR    = 16'h0200,
    ST_CAP_IR    = 16'h0400,
    ST_SHIFT_IR  = 16'h0800,
    ST_EXIT1_IR  = 16'h1000,
    ST_PAUSE_IR  = 16'h2000,
    ST_EXIT2_IR  = 16'h4000,
    ST_UPD_IR    = 16'h8000
  } jtc_tap_e;

  typedef enum logic [1:0] {
    CMD_RESET = 2'h0,
    CMD_IR    = 2'h1,
    CMD_DR    = 2'h2
  } jtc_cmd_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h1,
    HS_RUN  = 2'h2
  } jtc_host_e;

endpackage

// *** hw/jtc_if.sv ***
// four-wire test port link between scan controller and device
`timescale 1ns/1ps
`default_nettype none
interface jtc_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo_drv;
  logic tdo_oe;
  logic tdo;

  // undriven tdo floats to the board pull-up
  assign tdo = tdo_oe ? tdo_drv : 1'b1;

  modport dev (
    input  tck,
    input  tms,
    input  tdi,
    output tdo_drv,
    output tdo_oe
  );
  modport host (
    output tck,
    output tms,
    output tdi,
    input  tdo
  );
endinterface
`default_nettype wire

// *** hw/jtc_tap.sv ***
// test access port controller, instruction and data scan path
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - sixteen-state controller stepped by tms on tck rise
// - power-on reset enters Test-Logic-Reset
// - all scan registers shift lsb first
// - host: tms 1,1,0,0 from idle reaches Shift-IR
// - 4-bit instruction, msb taken leaving Shift-IR
// - Shift-IR outputs captured value 0x01
// - instruction latched in Update-IR; 1,1,0 back to idle
// - instruction selects and controls data register
// - host: tms 1,0,0 from idle reaches Shift-DR
// - host: tms low except with final data bit
// - Capture-DR loads parallel inputs, shifted out
// - latched data output changes only in Update-DR
// - exit and pause states only navigate
// - data access may skip idle; idle not always safe
// - five tms highs reach Test-Logic-Reset
// - no test-reset pin; power-on, tms and port-off hold only
// - fuse unprogrammed: pins released, controller held reset
// - fuse programmed, disable clear: port on, pull-ups
// - tdo undriven unless shifting
// - host: debugger watches and may pull device reset
// - Test-Logic-Reset selects identification instruction
module jtc_tap
  import jtc_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               rst_n,
  jtc_if.dev                      link,
  input  wire logic               test_port_enable_fuse,
  input  wire logic               test_port_disable_bit,
  output logic                    port_active,
  output logic                    in_idle,
  output logic [IR_W-1:0]         ir_out,
  output logic [USER_W-1:0]       user_out,
  output logic                    update_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // state of both domains

  typedef struct packed {
    jtc_tap_e              st;
    logic [IR_W-1:0]       ir_sr;
    logic [IR_W-1:0]       ir;
    logic [DR_MAX-1:0]     dr_sr;
    logic [USER_W-1:0]     user;
    logic                  upd_tgl;
    logic [1:0]            en_s;
  } jtc_tck_s;

  typedef struct packed {
    logic                  en;
    logic [2:0]            upd_s;
    logic [1:0]            idle_s;
    logic [IR_W-1:0]       ir_out;
    logic [USER_W-1:0]     user_out;
    logic                  upd_pulse;
  } jtc_sys_s;

  localparam jtc_tck_s TCK_RST = '{
    st:      ST_TLR,
    ir_sr:   '0,
    ir:      OP_IDCODE,
    dr_sr:   '0,
    user:    '0,
    upd_tgl: 1'b0,
    en_s:    2'h0
  };

  localparam jtc_sys_s SYS_RST = '{
    en:        1'b0,
    upd_s:     3'h0,
    idle_s:    2'h0,
    ir_out:    OP_IDCODE,
    user_out:  '0,
    upd_pulse: 1'b0
  };

  jtc_tck_s t_q;
  jtc_tck_s t_d;
  jtc_sys_s m_q;
  jtc_sys_s m_d;
  logic     tdo_q;
  logic     tdo_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic jtc_tap_e jtc_next(input jtc_tap_e s, input logic tms);
    jtc_tap_e n;
    n = ST_TLR;
    unique case (s)
      ST_TLR:      n = tms ? ST_TLR    : ST_IDLE;
      ST_IDLE:     n = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:   n = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:   n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: n = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: n = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR:   n = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:   n = tms ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR:   n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: n = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: n = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR:   n = tms ? ST_SEL_DR : ST_IDLE;
      default:     n = ST_TLR;
    endcase
    return n;
  endfunction

  // scan length of the register the instruction selects
  function automatic logic [5:0] jtc_dr_len(input logic [IR_W-1:0] op);
    logic [5:0] l;
    l = 6'h01;
    if (op == OP_IDCODE) begin
      l = 6'h20;
    end else if (op == OP_USER) begin
      l = 6'(USER_W);
    end
    return l;
  endfunction

  function automatic logic [DR_MAX-1:0] jtc_capture(
    input logic [IR_W-1:0]   op,
    input logic [USER_W-1:0] usr
  );
    logic [DR_MAX-1:0] c;
    c = '0;
    if (op == OP_IDCODE) begin
      c = ID_VALUE;
    end else if (op == OP_USER) begin
      c = DR_MAX'(usr);
    end
    return c;
  endfunction

  // tdi enters at the top of the selected length, lsb leaves first
  function automatic logic [DR_MAX-1:0] jtc_shift(
    input logic [DR_MAX-1:0] sr,
    input logic              din,
    input logic [5:0]        len
  );
    logic [DR_MAX-1:0] r;
    r = sr >> 1;
    r[5'(len - 6'h01)] = din;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain

  always_comb begin
    t_d = t_q;
    t_d.en_s = {t_q.en_s[0], m_q.en};
    t_d.st = jtc_next(t_q.st, link.tms);
    unique case (t_q.st)
      ST_TLR: begin
        t_d.ir = OP_IDCODE;
      end
      ST_CAP_IR: begin
        t_d.ir_sr = IR_CAPTURE;
      end
      ST_SHIFT_IR: begin
        t_d.ir_sr = {link.tdi, t_q.ir_sr[IR_W-1:1]};
      end
      ST_UPD_IR: begin
        t_d.ir = t_q.ir_sr;
        t_d.upd_tgl = ~t_q.upd_tgl;
      end
      ST_CAP_DR: begin
        t_d.dr_sr = jtc_capture(t_q.ir, t_q.user);
      end
      ST_SHIFT_DR: begin
        t_d.dr_sr = jtc_shift(t_q.dr_sr, link.tdi, jtc_dr_len(t_q.ir));
      end
      ST_UPD_DR: begin
        if (t_q.ir == OP_USER) begin
          t_d.user = t_q.dr_sr[USER_W-1:0];
          t_d.upd_tgl = ~t_q.upd_tgl;
        end
      end
      default: begin
        t_d.st = t_d.st;
      end
    endcase
    if (!t_q.en_s[1]) begin
      t_d.st = ST_TLR;
      t_d.ir = OP_IDCODE;
    end
  end

  // only power-on reset, no separate test reset pin
  always_ff @(posedge link.tck or negedge rst_n) begin
    if (!rst_n) begin
      t_q <= TCK_RST;
    end else begin
      t_q <= t_d;
    end
  end

  // falling-edge launch; the host samples it two mclk edges before the next fall, via a two-flop synchronizer
  always_ff @(negedge link.tck or negedge rst_n) begin
    if (!rst_n) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q    <= (t_q.st == ST_SHIFT_IR) ? t_q.ir_sr[0] : t_q.dr_sr[0];
      tdo_oe_q <= (t_q.st == ST_SHIFT_IR) || (t_q.st == ST_SHIFT_DR);
    end
  end

  assign link.tdo_drv = tdo_q;
  assign link.tdo_oe  = tdo_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // system domain

  always_comb begin
    m_d = m_q;
    m_d.en = test_port_enable_fuse & ~test_port_disable_bit;
    m_d.upd_s = {m_q.upd_s[1:0], t_q.upd_tgl};
    m_d.idle_s = {m_q.idle_s[0], t_q.st == ST_IDLE};
    m_d.upd_pulse = m_q.upd_s[2] ^ m_q.upd_s[1];
    if (m_q.upd_s[2] ^ m_q.upd_s[1]) begin
      m_d.ir_out   = t_q.ir;
      m_d.user_out = t_q.user;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      m_q <= SYS_RST;
    end else begin
      m_q <= m_d;
    end
  end

  assign port_active  = m_q.en;
  assign in_idle      = m_q.idle_s[1];
  assign ir_out       = m_q.ir_out;
  assign user_out     = m_q.user_out;
  assign update_pulse = m_q.upd_pulse;

endmodule // jtc_tap
`default_nettype wire

// *** hw/jtc_host.sv ***
// scan controller that drives the test port from a command port
`timescale 1ns/1ps
`default_nettype none
module jtc_host
  import jtc_pkg::*;
#(
  parameter int HALF = TCK_HALF
)(
  input  wire logic               mclk,
  input  wire logic               rst_n,
  jtc_if.host                     link,
  input  wire logic               cmd_valid,
  input  wire jtc_cmd_e           cmd_op,
  input  wire logic [5:0]         cmd_len,
  input  wire logic [DR_MAX-1:0]  cmd_data,
  output logic                    cmd_ready,
  output logic                    rsp_valid,
  output logic [DR_MAX-1:0]       rsp_data
);

  typedef struct packed {
    jtc_host_e          hs;
    logic [7:0]         cnt;
    logic [5:0]         idx;
    logic [5:0]         total;
    logic [5:0]         sh_lo;
    logic [5:0]         sh_hi;
    logic [5:0]         len;
    logic [VEC_W-1:0]   tms_v;
    logic [VEC_W-1:0]   tdi_v;
    logic [DR_MAX-1:0]  rx;
    logic               tck;
    logic               tms;
    logic               tdi;
    logic [1:0]         tdo_s;
    logic               ready;
    logic               rsp_valid;
    logic [DR_MAX-1:0]  rsp;
  } jtc_host_s;

  localparam jtc_host_s HOST_RST = '{
    hs: HS_IDLE, cnt: 8'h00, idx: 6'h00, total: 6'h00, sh_lo: 6'h00,
    sh_hi: 6'h00, len: 6'h00, tms_v: '0, tdi_v: '0, rx: '0, tck: 1'b0,
    tms: 1'b1, tdi: 1'b1, tdo_s: 2'h3, ready: 1'b1, rsp_valid: 1'b0,
    rsp: '0
  };

  jtc_host_s h_q;
  jtc_host_s h_d;

  ////////////////////////////////////////////////////////////////////////////
  // command sequencing, one tms/tdi bit per tck period

  always_comb begin
    logic [5:0]        p;
    logic [5:0]        l;
    logic [DR_MAX-1:0] rx_n;
    p = DR_PRE_LEN;
    l = cmd_len;
    rx_n = h_q.rx;
    h_d = h_q;
    h_d.rsp_valid = 1'b0;
    h_d.tdo_s = {h_q.tdo_s[0], link.tdo};
    unique case (h_q.hs)
      HS_IDLE: begin
        h_d.tck = 1'b0;
        if (cmd_valid) begin
          if (cmd_op == CMD_IR) begin
            p = IR_PRE_LEN;
            l = 6'(IR_W);
          end else if (l == 6'h00) begin
            l = 6'h01;
          end else if (l > 6'h20) begin
            l = 6'h20;
          end
          h_d.len   = l;
          h_d.sh_lo = p;
          h_d.sh_hi = 6'(p + l);
          h_d.total = 6'(p + l + 6'h02);
          // last data bit with tms high, then update and idle
          h_d.tms_v = (cmd_op == CMD_IR ? VEC_W'(IR_PRE) : VEC_W'(DR_PRE))
                    | (VEC_W'(1) << (p + l - 6'h01))
                    | (VEC_W'(1) << (p + l));
          h_d.tdi_v = VEC_W'(cmd_data) << p;
          if (cmd_op == CMD_RESET) begin
            h_d.tms_v = VEC_W'(RST_TMS);
            h_d.tdi_v = '1;
            h_d.total = RST_LEN;
            h_d.sh_lo = 6'h00;
            h_d.sh_hi = 6'h00;
          end
          h_d.hs    = HS_RUN;
          h_d.ready = 1'b0;
          h_d.cnt   = 8'h00;
          h_d.idx   = 6'h00;
          h_d.tms   = h_d.tms_v[0];
          h_d.tdi   = h_d.tdi_v[0];
        end
      end
      HS_RUN: begin
        h_d.cnt = 8'(h_q.cnt + 8'h01);
        if (h_q.cnt == 8'(HALF - 1)) begin
          h_d.tck = 1'b1;
        end
        if (h_q.cnt == 8'(2 * HALF - 1)) begin
          h_d.cnt = 8'h00;
          h_d.tck = 1'b0;
          if (h_q.idx >= h_q.sh_lo && h_q.idx < h_q.sh_hi) begin
            rx_n = {h_q.tdo_s[1], h_q.rx[DR_MAX-1:1]};
          end
          h_d.rx = rx_n;
          if (h_q.idx == 6'(h_q.total - 6'h01)) begin
            h_d.hs        = HS_IDLE;
            h_d.ready     = 1'b1;
            h_d.rsp_valid = 1'b1;
            h_d.rsp       = rx_n >> (6'h20 - h_q.len);
          end else begin
            h_d.idx = 6'(h_q.idx + 6'h01);
            h_d.tms = h_q.tms_v[6'(h_q.idx + 6'h01)];
            h_d.tdi = h_q.tdi_v[6'(h_q.idx + 6'h01)];
          end
        end
      end
      default: begin
        h_d = HOST_RST;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      h_q <= HOST_RST;
    end else begin
      h_q <= h_d;
    end
  end

  assign link.tck  = h_q.tck;
  assign link.tms  = h_q.tms;
  assign link.tdi  = h_q.tdi;
  assign cmd_ready = h_q.ready;
  assign rsp_valid = h_q.rsp_valid;
  assign rsp_data  = h_q.rsp;

endmodule // jtc_host
`default_nettype wire

// *** verification/jtc_chk.sv ***
// concurrent checks on the four-wire test port link
`timescale 1ns/1ps
`default_nettype none
module jtc_chk
  import jtc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_drv,
  input wire logic tdo_oe,
  input wire logic tdo,
  input wire logic port_active
);
  jtc_tap_e        st_q;
  jtc_tap_e        st_d;
  logic [5:0]      cnt_q;
  logic [IR_W-1:0] sh_q;
  logic [IR_W-1:0] ir_q;
  logic            sh;
  logic            off;
  ////////////////////////////////////////
  // shadow controller, held in reset while the port is off
  assign sh = st_q == ST_SHIFT_DR || st_q == ST_SHIFT_IR;
  assign off = !rst_n || !port_active;
  always_comb begin
    case (st_q)
      ST_IDLE:     st_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:   st_d = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:   st_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: st_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: st_d = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: st_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: st_d = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR:   st_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:   st_d = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR:   st_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: st_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: st_d = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: st_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: st_d = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR:   st_d = tms ? ST_SEL_DR : ST_IDLE;
      default:     st_d = tms ? ST_TLR : ST_IDLE;
    endcase
  end
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= ST_TLR;
      cnt_q <= 6'h00;
      sh_q  <= 4'h0;
      ir_q  <= OP_IDCODE;
    end else begin
      st_q  <= port_active ? st_d : ST_TLR;
      cnt_q <= sh ? cnt_q + 6'h01 : 6'h00;
      if (st_q == ST_SHIFT_IR)
        sh_q <= {tdi, sh_q[IR_W-1:1]};
      if (!port_active || st_d == ST_TLR)
        ir_q <= OP_IDCODE;
      else if (st_q == ST_UPD_IR)
        ir_q <= sh_q;
    end
  end
  ////////////////////////////////////////
  oe_in_shift_a:
    assert property (@(posedge tck) disable iff (off) tdo_oe == sh)
      else $error("tdo enable outside shift");
  tdo_on_fall_a:
    assert property (@(posedge mclk) disable iff (!rst_n)
      $changed(tdo_drv) || $changed(tdo_oe) |-> $fell(tck))
      else $error("tdo moved away from a tck fall");
  ir_capture_a:
    assert property (@(posedge tck) disable iff (off)
      st_q == ST_SHIFT_IR && cnt_q < 6'h04 |-> tdo == IR_CAPTURE[cnt_q[1:0]])
      else $error("wrong captured instruction bit");
  id_scan_a:
    assert property (@(posedge tck) disable iff (off)
      st_q == ST_SHIFT_DR && ir_q == OP_IDCODE |-> tdo == ID_VALUE[cnt_q[4:0]])
      else $error("wrong identification bit");
  bypass_path_a:
    assert property (@(posedge tck) disable iff (off)
      st_q == ST_SHIFT_DR && ir_q != OP_IDCODE && ir_q != OP_USER
      |-> tdo == (cnt_q != 6'h00 && $past(tdi)))
      else $error("bypass path not one stage");
  tms_reset_a:
    assert property (@(posedge tck) disable iff (off)
      tms [*5] ##1 !tms ##1 tms ##1 !tms [*2] |=> tdo_oe)
      else $error("five high tms did not reset");
  ir_tms_a:
    assert property (@(posedge tck) disable iff (off)
      st_q == ST_SHIFT_IR |-> tms == (cnt_q == 6'h03))
      else $error("instruction shift length wrong");
  ir_exit_a:
    assert property (@(posedge tck) disable iff (off)
      st_q == ST_EXIT1_IR |-> tms ##1 !tms)
      else $error("no return to idle after instruction");
endmodule // jtc_chk
`default_nettype wire

// *** verification/jtag_tap_controller_tb.sv ***
// self-checking bench: scan controller driving the test port
`timescale 1ns/1ps
`default_nettype none
module jtag_tap_controller_tb
  import jtc_pkg::*;
;
  logic              mclk;
  logic              rst_n;
  logic              fuse;
  logic              dis;
  logic              cmd_valid;
  jtc_cmd_e          cmd_op;
  logic [5:0]        cmd_len;
  logic [DR_MAX-1:0] cmd_data;
  logic              cmd_ready;
  logic              rsp_valid;
  logic [DR_MAX-1:0] rsp_data;
  logic              port_active;
  logic              in_idle;
  logic              upd;
  logic [IR_W-1:0]   ir_out;
  logic [USER_W-1:0] user_out;
  logic [USER_W-1:0] u_exp;
  logic [31:0]       seed;
  logic [3:0]        op;
  logic [5:0]        n;
  logic [3:0]        ops [8];
  int                err_total;
  int                n_checks;

  jtc_if ifc ();
  jtc_tap u_jtc_tap (.mclk(mclk), .rst_n(rst_n), .link(ifc),
    .test_port_enable_fuse(fuse), .test_port_disable_bit(dis),
    .port_active(port_active), .in_idle(in_idle), .ir_out(ir_out),
    .user_out(user_out), .update_pulse(upd));
  jtc_host u_jtc_host (.mclk(mclk), .rst_n(rst_n), .link(ifc),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_len(cmd_len),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  jtc_chk u_jtc_chk (.mclk(mclk), .rst_n(rst_n), .tck(ifc.tck),
    .tms(ifc.tms), .tdi(ifc.tdi), .tdo_drv(ifc.tdo_drv),
    .tdo_oe(ifc.tdo_oe), .tdo(ifc.tdo), .port_active(port_active));

  initial begin
    mclk = 1'b0;
    forever #(MCLK_PERIOD_NS / 2) mclk = ~mclk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [31:0] msk(input logic [5:0] w);
    return (w >= 6'h20) ? 32'hFFFFFFFF : (32'h1 << w) - 32'h1;
  endfunction
  // captured value: id, user latch, or one bypass stage
  function automatic logic [31:0] exp_dr(input logic [3:0] o,
      input logic [31:0] v, input logic [5:0] w);
    if (o == OP_IDCODE) return ID_VALUE & msk(w);
    if (o == OP_USER) return {24'h0, u_exp} & msk(w);
    return (v << 1) & msk(w);
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // one command; optional look at the user latch mid-shift
  task automatic run(input jtc_cmd_e c, input logic [5:0] w,
      input logic [31:0] v, input logic uchk);
    int   i;
    int   np;
    logic usr;
    i = 0;
    np = 0;
    usr = uchk;
    while (cmd_ready !== 1'b1) begin
      @(negedge mclk);
      i++;
      if (i > 100) begin
        err_total++;
        $display("[ERR] %0t command port stuck", $time);
        give_verdict();
      end
    end
    cmd_valid = 1'b1;
    cmd_op = c;
    cmd_len = w;
    cmd_data = v;
    @(negedge mclk);
    cmd_valid = 1'b0;
    i = 0;
    while (rsp_valid !== 1'b1) begin
      @(negedge mclk);
      i++;
      if (upd === 1'b1)
        np++;
      if (uchk && ifc.tdo_oe === 1'b1) begin
        chk_d({24'h0, user_out}, {24'h0, u_exp});
        uchk = 1'b0;
      end
      if (i > 1000) begin
        err_total++;
        $display("[ERR] %0t no response", $time);
        give_verdict();
      end
    end
    for (int j = 0; j < 4; j++) begin
      @(negedge mclk);
      if (upd === 1'b1)
        np++;
    end
    // one update pulse per instruction or user-register update
    chk_d(32'(np), {31'h0, c == CMD_IR || usr});
  endtask
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    fuse = 1'b1;
    dis = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = CMD_RESET;
    cmd_len = 6'h00;
    cmd_data = 32'h0;
    err_total = 0;
    n_checks = 0;
    seed = 32'h54;
    u_exp = 8'h00;
    ops = '{OP_IDCODE, OP_USER, OP_BYPASS, 4'h8, 4'h9, 4'hA, 4'hB, 4'h5};
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk_b(port_active, 1'b1);
    chk_d({28'h0, ir_out}, {28'h0, OP_IDCODE});
    chk_d({24'h0, user_out}, 32'h0);
    run(CMD_RESET, 6'h00, 32'h0, 1'b0);
    run(CMD_DR, 6'h20, 32'h0, 1'b0);
    chk_d(rsp_data, ID_VALUE);
    for (int k = 0; k < 20; k++) begin
      seed = xs(seed);
      op = (k < 8) ? ops[k] : ops[seed[2:0]];
      n = (k == 2) ? 6'h01 : {1'b0, seed[20:16]} + 6'h01;
      if (k == 3)
        n = 6'h20;
      if (op == OP_IDCODE)
        n = 6'h20;
      if (op == OP_USER)
        n = 6'h08;
      run(CMD_IR, 6'h04, {28'h0, op}, 1'b0);
      chk_d(rsp_data & 32'hF, {28'h0, IR_CAPTURE});
      chk_d({28'h0, ir_out}, {28'h0, op});
      chk_b(in_idle, 1'b1);
      run(CMD_DR, n, seed, op == OP_USER);
      chk_d(rsp_data & msk(n), exp_dr(op, seed, n));
      if (op == OP_USER)
        u_exp = seed[7:0];
      chk_d({24'h0, user_out}, {24'h0, u_exp});
    end
    dis = 1'b1;
    repeat (3) @(negedge mclk);
    chk_b(port_active, 1'b0);
    run(CMD_RESET, 6'h00, 32'h0, 1'b0);
    run(CMD_DR, 6'h20, 32'h0, 1'b0);
    chk_d(rsp_data, 32'hFFFFFFFF);
    fuse = 1'b0;
    dis = 1'b0;
    repeat (3) @(negedge mclk);
    chk_b(port_active, 1'b0);
    fuse = 1'b1;
    repeat (3) @(negedge mclk);
    chk_b(port_active, 1'b1);
    run(CMD_RESET, 6'h00, 32'h0, 1'b0);
    run(CMD_DR, 6'h20, 32'h0, 1'b0);
    chk_d(rsp_data, ID_VALUE);
    give_verdict();
  end
endmodule // jtag_tap_controller_tb
`default_nettype wire
